// ---- common/tmo_defs.vh ----
/*
 * register map, field positions, mode codes, reset values and timing counts
 * for the four-channel timer output block.
 * assumes a byte-addressed 32-bit bus with one aligned word per register.
 */
`ifndef TMO_DEFS_VH
`define TMO_DEFS_VH

// ****************************************
// register map: channel n at n * 0x20
// ****************************************
`define TMO_WIDX_CTL 3'h0
`define TMO_WIDX_IOC 3'h1
`define TMO_WIDX_CCR0 3'h2
`define TMO_WIDX_CCR1 3'h3
`define TMO_WIDX_STAT 3'h4

// ****************************************
// control word fields
// ****************************************
`define TMO_CTL_RUN 0
`define TMO_CTL_MD_LO 1
`define TMO_CTL_MD_HI 3
`define TMO_CTL_EXTCLK 4
`define TMO_CTL_SOFT 5
`define TMO_CTL_CCS0 6
`define TMO_CTL_CCS1 7
`define TMO_CTL_RST 8'h00

// ****************************************
// output control fields
// ****************************************
`define TMO_IOC_OEA 0
`define TMO_IOC_OLA 1
`define TMO_IOC_OEB 2
`define TMO_IOC_OLB 3
`define TMO_IOC_RST 4'h0

// ****************************************
// operating modes
// ****************************************
`define TMO_MD_INTV 3'h0
`define TMO_MD_EVT 3'h1
`define TMO_MD_ETP 3'h2
`define TMO_MD_OSP 3'h3
`define TMO_MD_PWM 3'h4
`define TMO_MD_FREE 3'h5
`define TMO_MD_PWMM 3'h6

// ****************************************
// counter values and timing
// ****************************************
`define TMO_CNT_IDLE 16'hffff
`define TMO_CNT_ZERO 16'h0000
`define TMO_CCR_RST 16'h0000
`define TMO_CLK_HZ 20000000
`define TMO_CNTCLK_HZ 5000000
`define TMO_PRESCALE (`TMO_CLK_HZ / `TMO_CNTCLK_HZ)

`endif

// ---- core/tmo_sync.v ----
/*
 * two-flop synchroniser with a rising-edge pulse per bit.
 * assumes asynchronous pin inputs and one core clock.
 */
`timescale 1ns/100ps
module tmo_sync #(
	parameter W = 2
) (
	input wire core_clk, // core clock
	input wire rst, // synchronous reset, high
	input wire [W-1:0] pinIn, // asynchronous pins
	output wire [W-1:0] rise // one-cycle pulse per rising edge
);
	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;
	reg [W-1:0] last_r;

	always @(posedge core_clk) begin
		if (rst) begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
			last_r <= {W{1'b0}};
		end else begin
			meta_r <= pinIn;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	// edge detect looks only at the second and third stages
	assign rise = sync_r & ~last_r;
endmodule // tmo_sync

// ---- core/tmo_prescale.v ----
/*
 * count clock enable: one-cycle pulse every DIV core clocks.
 * assumes DIV of at least 1.
 */
`timescale 1ns/100ps
module tmo_prescale #(
	parameter DIV = 4
) (
	input wire core_clk, // core clock
	input wire rst, // synchronous reset, high
	output reg tick // count clock enable pulse
);
	// a sized copy lets the compare take the low bits on purpose
	localparam [31:0] DIV_W = DIV;
	reg [15:0] div_r;

	always @(posedge core_clk) begin
		if (rst) begin
			div_r <= 16'h0000;
			tick <= 1'b0;
		end else if (div_r == DIV_W[15:0] - 16'h0001) begin
			div_r <= 16'h0000;
			tick <= 1'b1;
		end else begin
			div_r <= div_r + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule // tmo_prescale

// ---- core/tmo_timer_top.v ----
/*
 * four 16-bit timer channels with mode capability per channel, compare
 * buffering, capture, output pin control and match pulses, on AHB-Lite.
 * assumes one 20 MHz core clock, synchronous reset, zero-wait single word
 * transfers, and pin inputs that are asynchronous to the core clock.
 */
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "tmo_defs.vh"

module tmo_timer_top #(
	parameter PRESCALE = `TMO_PRESCALE
) (
	input wire core_clk, // core clock, 20 MHz
	input wire rst, // synchronous reset, high
	input wire hsel, // AHB slave select
	input wire [31:0] haddr, // AHB address
	input wire [1:0] htrans, // AHB transfer type
	input wire hwrite, // AHB write
	input wire [2:0] hsize, // AHB size, word only
	input wire [31:0] hwdata, // AHB write data
	input wire hready, // AHB bus ready
	output reg hreadyout, // AHB slave ready
	output reg hresp, // AHB response, always OKAY
	output reg [31:0] hrdata, // AHB read data
	input wire [1:0] timerInPin, // input pins of channels 0 and 2
	output reg timerOutA, // first output, channel 0
	output reg [3:0] timerOutB, // second outputs, bit 1 always low
	output reg [3:0] matchIrq0, // compare 0 match or capture pulse
	output reg [3:0] matchIrq1 // compare 1 match pulse
);
	// ****************************************
	// capability decode
	// ****************************************
	function modeOk;
		input integer ch;
		input [2:0] md;
		begin
			case (ch)
				1: modeOk = (md == `TMO_MD_INTV) || (md == `TMO_MD_FREE);
				3: modeOk = (md <= `TMO_MD_FREE) && (md != `TMO_MD_EVT);
				default: modeOk = (md <= `TMO_MD_PWMM);
			endcase
		end
	endfunction

	function isBatch;
		input [2:0] md;
		begin
			isBatch = (md == `TMO_MD_ETP) || (md == `TMO_MD_PWM);
		end
	endfunction

	function pinLevel;
		input level;
		input enable;
		input active;
		input toggle;
		begin
			// polarity is applied last so a level change acts at once
			pinLevel = level ^ (enable && active && toggle);
		end
	endfunction

	// ****************************************
	// bus slave
	// ****************************************
	reg wrEn_r;
	reg [1:0] wrCh_r;
	reg [2:0] wrIdx_r;
	wire accept = hsel && htrans[1] && hready;
	wire [1:0] rdCh = haddr[6:5];
	wire [2:0] rdIdx = haddr[4:2];
	wire rdMapped = !haddr[7] && (rdIdx <= `TMO_WIDX_STAT);
	wire [127:0] rdAll;
	wire [1:0] inRise;
	wire pTick;

	always @(posedge core_clk) begin
		if (rst) begin
			wrEn_r <= 1'b0;
			wrCh_r <= 2'd0;
			wrIdx_r <= 3'd0;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			// zero wait states: read data registered at the address phase
			wrEn_r <= accept && hwrite && rdMapped;
			wrCh_r <= rdCh;
			wrIdx_r <= rdIdx;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (accept && !hwrite && rdMapped) begin
				hrdata <= rdAll[rdCh*32 +: 32];
			end else if (accept) begin
				hrdata <= 32'h00000000;
			end
		end
	end

	tmo_sync #(.W(2)) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.pinIn(timerInPin),
		.rise(inRise)
	);

	// one divider serves every channel outside event count and external clock, so those count in step
	tmo_prescale #(.DIV(PRESCALE)) u_pre (
		.core_clk(core_clk),
		.rst(rst),
		.tick(pTick)
	);

	// ****************************************
	// channels
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_ch
			reg [7:0] ctl_r;
			reg [3:0] ioc_r;
			reg [15:0] ccr0_r, ccr1_r, buf0_r, buf1_r, cnt_r;
			reg armed_r, started_r, runPrev_r, pend_r, togA_r, togB_r;
			wire hasIn = (gi == 0) || (gi == 2);
			wire pinEdge = (gi == 0) ? inRise[0] : ((gi == 2) ? inRise[1] : 1'b0);
			wire [2:0] md = ctl_r[`TMO_CTL_MD_HI:`TMO_CTL_MD_LO];
			wire run = ctl_r[`TMO_CTL_RUN] && modeOk(gi, md);
			wire wrHit = wrEn_r && (wrCh_r == gi);
			wire wrCtl = wrHit && (wrIdx_r == `TMO_WIDX_CTL);
			wire wrCcr0 = wrHit && (wrIdx_r == `TMO_WIDX_CCR0);
			wire wrCcr1 = wrHit && (wrIdx_r == `TMO_WIDX_CCR1);
			wire trigMode = (md == `TMO_MD_ETP) || (md == `TMO_MD_OSP);
			// ext trigger on channels with an input pin only
			wire trig = trigMode && ((wrCtl && hwdata[`TMO_CTL_SOFT])
				|| (hasIn && pinEdge));
			// event count takes every rising edge; there is no edge-select field
			wire tick = ((md == `TMO_MD_EVT) || ctl_r[`TMO_CTL_EXTCLK]) ? pinEdge : pTick;
			wire capMode = hasIn && ((md == `TMO_MD_PWMM)
				|| ((md == `TMO_MD_FREE) && ctl_r[`TMO_CTL_CCS0]));
			wire cmp1Off = (md == `TMO_MD_PWMM) || ((md == `TMO_MD_FREE)
				&& ctl_r[`TMO_CTL_CCS1] && hasIn);
			wire capEv = run && started_r && capMode && pinEdge;
			wire m0 = run && started_r && tick && !capMode && (cnt_r == buf0_r);
			wire m1 = run && started_r && tick && !cmp1Off && (cnt_r == buf1_r);
			// the first tick after arming is the ffff to 0000 step, not a match
			wire startNow = run && armed_r && tick;
			wire bActive = (gi != 1) && (md != `TMO_MD_EVT) && (md != `TMO_MD_PWMM) && !cmp1Off;
			wire aActive = (gi == 0) && (md != `TMO_MD_PWMM);
			wire batch = isBatch(md);

			// ****************************************
			// channel registers and counter
			// ****************************************
			always @(posedge core_clk) begin
				if (rst) begin
					ctl_r <= `TMO_CTL_RST;
					ioc_r <= `TMO_IOC_RST;
					ccr0_r <= `TMO_CCR_RST;
					ccr1_r <= `TMO_CCR_RST;
					buf0_r <= `TMO_CCR_RST;
					buf1_r <= `TMO_CCR_RST;
					cnt_r <= `TMO_CNT_IDLE;
					armed_r <= 1'b0;
					started_r <= 1'b0;
					runPrev_r <= 1'b0;
					pend_r <= 1'b0;
					togA_r <= 1'b0;
					togB_r <= 1'b0;
				end else begin
					runPrev_r <= run;
					if (wrCtl) begin
						// soft trigger is a strobe and is not stored
						ctl_r <= hwdata[7:0] & ~(8'h01 << `TMO_CTL_SOFT);
					end
					if (wrHit && (wrIdx_r == `TMO_WIDX_IOC)) begin
						ioc_r <= hwdata[3:0];
					end
					if (wrCcr0) begin
						ccr0_r <= hwdata[15:0];
					end
					if (wrCcr1) begin
						ccr1_r <= hwdata[15:0];
					end
					// anytime write: buffer follows the register in the write cycle
					if (wrCcr0 && !batch) begin
						buf0_r <= hwdata[15:0];
					end
					if (wrCcr1 && !batch) begin
						buf1_r <= hwdata[15:0];
					end
					// a ccr1 write in the match cycle keeps the transfer pending
					pend_r <= (pend_r && !m0) || wrCcr1;
					// stopping clears the count and a capture value, compares survive
					if (!run) begin
						cnt_r <= `TMO_CNT_IDLE;
						armed_r <= 1'b0;
						started_r <= 1'b0;
						togA_r <= 1'b0;
						togB_r <= 1'b0;
						if (capMode) begin
							ccr0_r <= `TMO_CCR_RST;
						end
					end else if (trig || (!trigMode && !runPrev_r)) begin
						// retrigger restarts the count from the idle value
						cnt_r <= `TMO_CNT_IDLE;
						armed_r <= 1'b1;
						started_r <= 1'b0;
					end else if (startNow) begin
						cnt_r <= `TMO_CNT_ZERO;
						armed_r <= 1'b0;
						started_r <= 1'b1;
						togA_r <= ~togA_r;
						togB_r <= ~togB_r;
						buf0_r <= ccr0_r;
						buf1_r <= ccr1_r;
					end else if (capEv) begin
						ccr0_r <= cnt_r;
						if (md == `TMO_MD_PWMM) begin
							cnt_r <= `TMO_CNT_ZERO;
						end
					end else if (started_r && tick) begin
						if (m0 && (md == `TMO_MD_OSP)) begin
							// one shot ends and waits for the next trigger
							cnt_r <= `TMO_CNT_IDLE;
							started_r <= 1'b0;
						end else if (m0 && (md != `TMO_MD_FREE)) begin
							cnt_r <= `TMO_CNT_ZERO;
						end else begin
							cnt_r <= cnt_r + 16'h0001;
						end
						if (m0) begin
							togA_r <= ~togA_r;
						end
						if (m1) begin
							togB_r <= ~togB_r;
						end
						if (m0 && batch && pend_r) begin
							buf0_r <= ccr0_r;
							buf1_r <= ccr1_r;
						end
					end
				end
			end

			// ****************************************
			// status and readback
			// ****************************************
			assign rdAll[gi*32 +: 32] =
				(rdIdx == `TMO_WIDX_CTL) ? {24'h000000, ctl_r} :
				(rdIdx == `TMO_WIDX_IOC) ? {28'h0000000, ioc_r} :
				(rdIdx == `TMO_WIDX_CCR0) ? {16'h0000, ccr0_r} :
				(rdIdx == `TMO_WIDX_CCR1) ? {16'h0000, ccr1_r} :
				{13'h0000, started_r, togB_r, togA_r, run ? cnt_r : `TMO_CNT_ZERO};

			// ****************************************
			// output pins and match pulses
			// ****************************************
			// level select only flips polarity, so it acts without the toggle
			always @(posedge core_clk) begin
				if (rst) begin
					timerOutB[gi] <= 1'b0;
					matchIrq0[gi] <= 1'b0;
					matchIrq1[gi] <= 1'b0;
				end else begin
					timerOutB[gi] <= (gi != 1) && pinLevel(ioc_r[`TMO_IOC_OLB],
						ioc_r[`TMO_IOC_OEB], run && bActive, togB_r);
					matchIrq0[gi] <= m0 || capEv;
					matchIrq1[gi] <= m1;
				end
			end

			if (gi == 0) begin : g_outa
				always @(posedge core_clk) begin
					if (rst) begin
						timerOutA <= 1'b0;
					end else begin
						timerOutA <= pinLevel(ioc_r[`TMO_IOC_OLA], ioc_r[`TMO_IOC_OEA],
							run && aActive, togA_r);
					end
				end
			end
		end
	endgenerate
endmodule // tmo_timer_top

// ---- verif/tmo_pin_src.sv ----
/* far-side source for the two timer input pins.
   assumes one-cycle requests on the core clock; pins idle low. */
`timescale 1ns/100ps
module tmo_pin_src (
	input wire core_clk, // core clock
	input wire [1:0] pulseReq, // start a pin pulse
	output reg [1:0] timerInPin // input pins
);
	reg [2:0] holdCnt_r;
	initial timerInPin = 2'h0;
	initial holdCnt_r = 3'h0;
	// held for several clocks and moved off the edge: pins are asynchronous
	always @(posedge core_clk) begin
		if (pulseReq != 2'h0) begin
			timerInPin <= #7 pulseReq;
			holdCnt_r <= 3'h6;
		end else if (holdCnt_r != 3'h0) begin
			holdCnt_r <= holdCnt_r - 3'h1;
		end else begin
			timerInPin <= #7 2'h0;
		end
	end
endmodule // tmo_pin_src

// ---- verif/tmo_timer_top_properties.sv ----
/* port checker for the timer block.
   bound to the top module; sees only its ports. */
`timescale 1ns/100ps
module tmo_props (
	input wire core_clk, // clock
	input wire rst, // reset
	input wire hsel, // select
	input wire [31:0] haddr, // address
	input wire [1:0] htrans, // type
	input wire hwrite, // write
	input wire [31:0] hwdata, // write data
	input wire hready, // ready in
	input wire hreadyout, // ready out
	input wire hresp, // response
	input wire [31:0] hrdata, // read data
	input wire timerOutA, // first out
	input wire [3:0] timerOutB, // second outs
	input wire [3:0] matchIrq0, // match 0
	input wire [3:0] matchIrq1 // match 1
);
	// ****************
	// helpers
	// ****************
	wire taken = hsel && htrans[1] && hready;
	reg iocA_r;
	always @(posedge core_clk) begin
		iocA_r <= !rst && taken && hwrite && haddr == 32'h00000004;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	hready_one_a: assert property (hreadyout) else $error("slave stalled");
	okay_resp_a: assert property (!hresp) else $error("error response");
	chan1_nopin_a: assert property (!timerOutB[1]) else $error("chan 1 pin moved");
	reset_quiet_a: assert property (disable iff (1'b0) rst |=>
		(timerOutA == 1'b0 && timerOutB == 4'h0 && matchIrq0 == 4'h0 && hrdata == 32'h0))
		else $error("outputs active after reset");
	level_static_a: assert property (iocA_r && !hwdata[0] |->
		##2 timerOutA == $past(hwdata[1], 2)) else $error("static level wrong");
	write_zero_a: assert property (taken && hwrite |=> hrdata == 32'h0)
		else $error("read data on write");
	unmapped_zero_a: assert property (taken && !hwrite && haddr[7] |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	trig_reads_a: assert property (taken && !hwrite && !haddr[7] && haddr[4:0] == 5'h00 |=>
		!hrdata[5]) else $error("trigger bit reads one");
endmodule // tmo_props
bind tmo_timer_top tmo_props u_props (.core_clk(core_clk), .rst(rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timerOutA(timerOutA),
	.timerOutB(timerOutB), .matchIrq0(matchIrq0), .matchIrq1(matchIrq1));

// ---- verif/tmo_timer_top_bench.sv ----
/* self-checking bench for the timer block.
   drives AHB-Lite and the pin source; prescale of 1 keeps counts short. */
`timescale 1ns/100ps
module tmo_timer_top_bench;
	reg core_clk, rst, hsel, hwrite;
	reg [31:0] haddr, hwdata, rd;
	reg [1:0] htrans, pulseReq;
	wire hreadyout, hresp, timerOutA;
	wire [31:0] hrdata;
	wire [1:0] timerInPin;
	wire [3:0] timerOutB, matchIrq0, matchIrq1;
	integer badCount, comparisons, i, j, k, waitN;
	tmo_timer_top #(.PRESCALE(1)) DUT (.core_clk(core_clk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.timerInPin(timerInPin), .timerOutA(timerOutA), .timerOutB(timerOutB),
		.matchIrq0(matchIrq0), .matchIrq1(matchIrq1));
	tmo_pin_src far (.core_clk(core_clk), .pulseReq(pulseReq), .timerInPin(timerInPin));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// ****************
	// tasks
	// ****************
	task giveVerdict;
		begin
			if (badCount == 0 && comparisons > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task check(input [31:0] got, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				badCount = badCount + 1;
				$display("ERROR %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task cycles(input integer n);
		repeat (n) @(posedge core_clk);
	endtask
	task wait_ready;
		integer n;
		begin
			n = 0;
			@(posedge core_clk);
			while (hreadyout !== 1'b1) begin
				n = n + 1;
				if (n > 50) begin
					check(32'h1, 32'h0);
					giveVerdict;
				end
				@(posedge core_clk);
			end
		end
	endtask
	task bus(input wr, input [31:0] a, input [31:0] d);
		begin
			hsel <= 1'b1;
			htrans <= 2'h2;
			hwrite <= wr;
			haddr <= a;
			wait_ready;
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= d;
			wait_ready;
			rd = hrdata;
		end
	endtask
	task wait_hit(input which, input [1:0] ch);
		begin
			waitN = 0;
			@(posedge core_clk);
			while ((which ? matchIrq1[ch] : matchIrq0[ch]) !== 1'b1 && waitN < 200) begin
				waitN = waitN + 1;
				@(posedge core_clk);
			end
			check(waitN < 200, 1);
			if (waitN >= 200)
				giveVerdict;
		end
	endtask
	// ****************
	// sequence
	// ****************
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		pulseReq = 2'h0;
		badCount = 0;
		comparisons = 0;
		cycles(2);
		rst <= 1'b0;
		cycles(1);
		for (i = 0; i < 20; i = i + 1) begin
			bus(0, (i / 5) * 32 + (i % 5) * 4, 0);
			check(rd, 32'h0);
		end
		bus(0, 32'h80, 0);
		check(rd, 32'h0);
		bus(1, 32'h44, 32'h8);
		cycles(3);
		check(timerOutB[2], 1);
		for (i = 0; i < 2; i = i + 1) begin
			bus(1, 32'h8, 32'h1f);
			bus(1, 32'h4, 1 + 2 * i);
			cycles(3);
			check(timerOutA, i);
			bus(1, 32'h0, 32'h1);
			cycles(4);
			check(timerOutA, 1 - i);
			wait_hit(0, 0);
			cycles(2);
			check(timerOutA, i);
			bus(1, 32'h0, 32'h0);
			cycles(3);
			check(timerOutA, i);
		end
		// output enable low keeps the pin static while counting
		bus(1, 32'h4, 32'h2);
		bus(1, 32'h0, 32'h1);
		cycles(40);
		check(timerOutA, 1);
		bus(1, 32'h0, 32'h0);
		// interval takes a new compare at once, PWM only after a compare 1 write
		for (k = 0; k < 2; k = k + 1) begin
			bus(1, 32'h8, 32'h20);
			bus(1, 32'hc, 32'h10);
			bus(1, 32'h0, 1 + 8 * k);
			wait_hit(0, 0);
			bus(1, 32'h8, 32'h4);
			wait_hit(0, 0);
			wait_hit(0, 0);
			check(waitN, k ? 32 : 4);
			bus(1, 32'hc, 32'h10);
			wait_hit(0, 0);
			wait_hit(0, 0);
			check(waitN, 4);
			bus(1, 32'h0, 32'h0);
		end
		for (i = 1; i < 4; i = i + 1) begin
			bus(1, i * 32 + 8, 5);
			bus(1, i * 32 + 12, 2);
			bus(1, i * 32, 1);
			wait_hit(1, i[1:0]);
			wait_hit(0, i[1:0]);
			bus(1, i * 32, 0);
		end
		for (i = 0; i < 7; i = i + 1) begin
			j = (i < 5) ? 32 : 96;
			k = (i < 5) ? i + 1 + (i > 3) : 1 + 5 * (i - 5);
			bus(1, j, k * 2 + 1);
			cycles(6);
			bus(0, j + 16, 0);
			check(rd, 32'h0);
			bus(1, j, 0);
		end
		bus(1, 32'h68, 32'hfff);
		for (k = 2; k < 4; k = k + 1) begin
			bus(1, 32'h60, k * 2 + 1);
			cycles(4);
			bus(0, 32'h70, 0);
			check(rd[18], 0);
			bus(1, 32'h60, k * 2 + 33);
			cycles(4);
			bus(0, 32'h70, 0);
			check(rd[18], 1);
			bus(0, 32'h60, 0);
			check(rd, k * 2 + 1);
			bus(1, 32'h60, 0);
		end
		// edge-select fields do not exist here, so nothing to clear first
		for (i = 0; i < 2; i = i + 1) begin
			bus(1, i * 64 + 8, 32'hfff);
			bus(1, i * 64, 32'h5);
			cycles(4);
			bus(0, i * 64 + 16, 0);
			check(rd[18], 0);
			pulseReq <= 2'h1 << i;
			cycles(1);
			pulseReq <= 2'h0;
			cycles(12);
			bus(0, i * 64 + 16, 0);
			check(rd[18], 1);
			bus(1, i * 64, 0);
		end
		// event count: no edge-select field exists, so every rising edge counts
		bus(1, 32'h40, 32'h3);
		for (k = 0; k < 3; k = k + 1) begin
			pulseReq <= 2'h2;
			cycles(1);
			pulseReq <= 2'h0;
			cycles(12);
		end
		bus(0, 32'h50, 0);
		check(rd, 32'h00070002);
		bus(1, 32'h40, 32'h0);
		// second output of channel 2: free-running compare, free-running with compare 1 off, measurement
		bus(1, 32'h44, 32'h4);
		for (k = 0; k < 3; k = k + 1) begin
			bus(1, 32'h40, (k == 0) ? 32'hb : ((k == 1) ? 32'h8b : 32'hd));
			cycles(4);
			check(timerOutB[2], k == 0);
			bus(1, 32'h40, 32'h0);
		end
		check(timerOutB[1], 0);
		giveVerdict;
	end
endmodule // tmo_timer_top_bench
